// *** hw/exec_pkg.sv ***
// shared constants, opcodes and states of the flag-branch, bit and shift executor
package exec_pkg;

    // operations presented on the issue port
    typedef enum logic [3:0] {
        OP_NONE                   = 4'h0,
        OP_BRANCH_HALF_CARRY_SET  = 4'h1,
        OP_BRANCH_HALF_CARRY_CLR  = 4'h2,
        OP_BRANCH_TRANSFER_SET    = 4'h3,
        OP_BRANCH_TRANSFER_CLR    = 4'h4,
        OP_BRANCH_OVERFLOW_SET    = 4'h5,
        OP_BRANCH_OVERFLOW_CLR    = 4'h6,
        OP_BRANCH_IRQ_ENABLED     = 4'h7,
        OP_BRANCH_IRQ_DISABLED    = 4'h8,
        OP_SET_IO_BIT             = 4'h9,
        OP_CLEAR_IO_BIT           = 4'ha,
        OP_LOGICAL_SHIFT_LEFT     = 4'hb,
        OP_LOGICAL_SHIFT_RIGHT    = 4'hc
    } op_t;

    // execution stage states
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_EXEC     = 2'b01,
        ST_BRANCH2  = 2'b10,
        ST_IO_WRITE = 2'b11
    } state_t;

    // bit positions inside the status byte
    localparam int FLAG_CARRY      = 0;
    localparam int FLAG_ZERO       = 1;
    localparam int FLAG_NEGATIVE   = 2;
    localparam int FLAG_OVERFLOW   = 3;
    localparam int FLAG_SIGN       = 4;
    localparam int FLAG_HALF_CARRY = 5;
    localparam int FLAG_TRANSFER   = 6;
    localparam int FLAG_IRQ_ENABLE = 7;

    // data width of registers and status byte
    localparam int DATA_W = 8;
    localparam int MSB    = DATA_W - 1;
    localparam int LSB    = 0;

    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;

    // cycles spent in the execution stage
    localparam int CYC_BRANCH_NOT_TAKEN = 1;
    localparam int CYC_BRANCH_TAKEN     = 2;
    localparam int CYC_IO_BIT           = 2;
    localparam int CYC_SHIFT            = 1;

endpackage

// *** hw/flag_branch_bit_shift_exec.sv ***
// executor for flag branches, i/o bit set/clear and logical shifts
`timescale 1ns/10ps
`default_nettype none
module flag_branch_bit_shift_exec
    import exec_pkg::*;
#(
    parameter int PC_W      = 16,
    parameter int DISP_W    = 7,
    parameter int IO_ADDR_W = 5,
    parameter int REG_DEPTH = 32
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // issue port
    input  wire logic                 instrValid,
    output logic                      instrReady,
    input  wire op_t                  instrOp,
    input  wire logic [DISP_W-1:0]    instrDisp,
    input  wire logic [4:0]           instrReg,
    input  wire logic [IO_ADDR_W-1:0] instrIoAddr,
    input  wire logic [2:0]           instrBit,
    // status byte load from the rest of the core
    input  wire logic                 flagLoad,
    input  wire logic [7:0]           flagLoadData,
    output logic      [7:0]           statusFlags,
    // register file load from the rest of the core
    input  wire logic                 regLoad,
    input  wire logic [4:0]           regLoadAddr,
    input  wire logic [7:0]           regLoadData,
    // register write-back report
    output logic                      wbValid,
    output logic      [4:0]           wbAddr,
    output logic      [7:0]           wbData,
    // program counter
    output logic      [PC_W-1:0]      pc,
    output logic                      branchTaken,
    // i/o register space
    output logic      [IO_ADDR_W-1:0] ioAddr,
    output logic                      ioRdEn,
    input  wire logic [7:0]           ioRdData,
    output logic                      ioWrEn,
    output logic      [7:0]           ioWrData
);

    localparam int REG_AW = 5;

    // parameter checks
    if (DISP_W < 2 || DISP_W > PC_W) begin : g_chk_disp
        $error("flag_branch_bit_shift_exec: DISP_W must lie in 2..PC_W");
    end
    if (REG_DEPTH > (1 << REG_AW) || REG_DEPTH < 1) begin : g_chk_depth
        $error("flag_branch_bit_shift_exec: REG_DEPTH must lie in 1..32");
    end

    // execution stage state
    state_t                 state_q;
    state_t                 state_d;
    op_t                    op_q;
    op_t                    op_d;
    logic [DISP_W-1:0]      disp_q;
    logic [DISP_W-1:0]      disp_d;
    logic [4:0]             regAddr_q;
    logic [4:0]             regAddr_d;
    logic [IO_ADDR_W-1:0]   ioAddr_q;
    logic [IO_ADDR_W-1:0]   ioAddr_d;
    logic [2:0]             bit_q;
    logic [2:0]             bit_d;
    logic                   ioFwd_q;
    logic                   ioFwd_d;

    // architectural state and outputs
    logic [PC_W-1:0]        pc_q;
    logic [PC_W-1:0]        pc_d;
    logic [7:0]             flags_q;
    logic [7:0]             flags_d;
    logic                   branch_q;
    logic                   branch_d;
    logic [7:0]             ioWrData_q;
    logic [7:0]             ioWrData_d;
    logic                   wbValid_q;
    logic                   wbValid_d;
    logic [4:0]             wbAddr_q;
    logic [4:0]             wbAddr_d;
    logic [7:0]             wbData_q;
    logic [7:0]             wbData_d;

    // decode and datapath helpers
    logic                   accept;
    logic                   done;
    logic                   isBranch;
    logic                   isIoBit;
    logic                   isShift;
    logic                   condTrue;
    logic [7:0]             regRdData;
    logic [7:0]             shiftRes;
    logic                   shiftOut;
    logic [7:0]             ioBase;
    logic [7:0]             bitMask;
    logic [PC_W-1:0]        dispExt;
    logic                   rfWrEn;
    logic [4:0]             rfWrAddr;
    logic [7:0]             rfWrData;

    // operation class of the instruction in the execution stage
    always_comb begin
        isBranch = (op_q >= OP_BRANCH_HALF_CARRY_SET) && (op_q <= OP_BRANCH_IRQ_DISABLED);
        isIoBit  = (op_q == OP_SET_IO_BIT) || (op_q == OP_CLEAR_IO_BIT);
        isShift  = (op_q == OP_LOGICAL_SHIFT_LEFT) || (op_q == OP_LOGICAL_SHIFT_RIGHT);
    end

    // branch condition from the current status byte
    always_comb begin
        case (op_q)
            OP_BRANCH_HALF_CARRY_SET: condTrue = flags_q[FLAG_HALF_CARRY];
            OP_BRANCH_HALF_CARRY_CLR: condTrue = !flags_q[FLAG_HALF_CARRY];
            OP_BRANCH_TRANSFER_SET:   condTrue = flags_q[FLAG_TRANSFER];
            OP_BRANCH_TRANSFER_CLR:   condTrue = !flags_q[FLAG_TRANSFER];
            OP_BRANCH_OVERFLOW_SET:   condTrue = flags_q[FLAG_OVERFLOW];
            OP_BRANCH_OVERFLOW_CLR:   condTrue = !flags_q[FLAG_OVERFLOW];
            OP_BRANCH_IRQ_ENABLED:    condTrue = flags_q[FLAG_IRQ_ENABLE];
            OP_BRANCH_IRQ_DISABLED:   condTrue = !flags_q[FLAG_IRQ_ENABLE];
            default:                  condTrue = 1'b0;
        endcase
    end

    // sign-extended displacement
    assign dispExt = PC_W'($signed(disp_q));

    // shifter: zero fill, carry from the bit pushed out
    always_comb begin
        if (op_q == OP_LOGICAL_SHIFT_LEFT) begin
            shiftRes = {regRdData[MSB-1:LSB], 1'b0};
            shiftOut = regRdData[MSB];
        end else begin
            shiftRes = {1'b0, regRdData[MSB:LSB+1]};
            shiftOut = regRdData[LSB];
        end
    end

    // i/o read-modify-write: forwarded value if the prior write hit the same address
    always_comb begin
        ioBase  = ioFwd_q ? ioWrData_q : ioRdData;
        bitMask = 8'h01 << bit_q;
    end

    // completion of the instruction held in the execution stage
    always_comb begin
        case (state_q)
            ST_EXEC:     done = !((isBranch && condTrue) || isIoBit);
            ST_BRANCH2:  done = 1'b1;
            ST_IO_WRITE: done = !(instrValid && (instrIoAddr != ioAddr_q) && // one i/o address
                                  ((instrOp == OP_SET_IO_BIT) || (instrOp == OP_CLEAR_IO_BIT)));
            default:     done = 1'b0;
        endcase
        instrReady = (state_q == ST_IDLE) || done;
        accept     = instrValid && instrReady;
    end

    // register file port: shift write-back wins over an outside load
    always_comb begin
        rfWrEn   = regLoad;
        rfWrAddr = regLoadAddr;
        rfWrData = regLoadData;
        if (state_q == ST_EXEC && isShift) begin
            rfWrEn   = 1'b1;
            rfWrAddr = regAddr_q;
            rfWrData = shiftRes;
        end
    end

    reg_file_mem #(
        .DEPTH  (REG_DEPTH),
        .WIDTH  (DATA_W),
        .ADDR_W (REG_AW)
    ) u_regs (
        .clk_sys (clk_sys),
        .wrEn    (rfWrEn),
        .wrAddr  (rfWrAddr),
        .wrData  (rfWrData),
        .rdEn    (accept),
        .rdAddr  (instrReg),
        .rdData  (regRdData)
    );

    // i/o port: read launched on accept, write from a register
    always_comb begin
        ioRdEn = accept && ((instrOp == OP_SET_IO_BIT) || (instrOp == OP_CLEAR_IO_BIT));
        ioAddr = ioRdEn ? instrIoAddr : ioAddr_q;
        ioWrEn = (state_q == ST_IO_WRITE);
    end

    // next state of the execution stage
    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        disp_d    = disp_q;
        regAddr_d = regAddr_q;
        ioAddr_d  = ioAddr_q;
        bit_d     = bit_q;
        ioFwd_d   = 1'b0;
        case (state_q)
            ST_EXEC: begin
                if (isBranch && condTrue) begin
                    state_d = ST_BRANCH2;
                end else if (isIoBit) begin
                    state_d = ST_IO_WRITE;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_BRANCH2:  state_d = ST_IDLE;
            ST_IO_WRITE: state_d = ST_IDLE;
            ST_IDLE:     state_d = ST_IDLE;
            default:     state_d = ST_IDLE;
        endcase
        if (accept) begin
            state_d   = ST_EXEC;
            op_d      = instrOp;
            disp_d    = instrDisp;
            regAddr_d = instrReg;
            ioAddr_d  = instrIoAddr;
            bit_d     = instrBit;
            ioFwd_d   = ioWrEn && (ioAddr_q == instrIoAddr);
        end
    end

    // next pc, status byte and reported results
    always_comb begin
        pc_d       = pc_q;
        flags_d    = flagLoad ? flagLoadData : flags_q;
        branch_d   = 1'b0;
        ioWrData_d = ioWrData_q;
        wbValid_d  = 1'b0;
        wbAddr_d   = wbAddr_q;
        wbData_d   = wbData_q;
        case (state_q)
            ST_EXEC: begin
                if ((isBranch && !condTrue) || isShift || (op_q == OP_NONE)) begin
                    pc_d = pc_q + PC_W'(1);
                end
                if (isIoBit) begin
                    if (op_q == OP_SET_IO_BIT) begin
                        ioWrData_d = ioBase | bitMask;
                    end else begin
                        ioWrData_d = ioBase & ~bitMask;
                    end
                end
                if (isShift) begin
                    flags_d[FLAG_ZERO]     = (shiftRes == DATA_RESET);
                    flags_d[FLAG_CARRY]    = shiftOut;
                    flags_d[FLAG_NEGATIVE] = shiftRes[MSB];
                    flags_d[FLAG_OVERFLOW] = shiftRes[MSB] ^ shiftOut;
                    wbValid_d = 1'b1;
                    wbAddr_d  = regAddr_q;
                    wbData_d  = shiftRes;
                end
            end
            ST_BRANCH2: begin
                pc_d     = pc_q + dispExt + PC_W'(1);
                branch_d = 1'b1;
            end
            ST_IO_WRITE: pc_d = pc_q + PC_W'(1);
            default:     pc_d = pc_q;
        endcase
    end

    // execution stage registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            op_q      <= OP_NONE;
            disp_q    <= '0;
            regAddr_q <= '0;
            ioAddr_q  <= '0;
            bit_q     <= '0;
            ioFwd_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            op_q      <= op_d;
            disp_q    <= disp_d;
            regAddr_q <= regAddr_d;
            ioAddr_q  <= ioAddr_d;
            bit_q     <= bit_d;
            ioFwd_q   <= ioFwd_d;
        end
    end

    // architectural and output registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_q       <= '0;
            flags_q    <= FLAGS_RESET;
            branch_q   <= 1'b0;
            ioWrData_q <= DATA_RESET;
            wbValid_q  <= 1'b0;
            wbAddr_q   <= '0;
            wbData_q   <= DATA_RESET;
        end else begin
            pc_q       <= pc_d;
            flags_q    <= flags_d;
            branch_q   <= branch_d;
            ioWrData_q <= ioWrData_d;
            wbValid_q  <= wbValid_d;
            wbAddr_q   <= wbAddr_d;
            wbData_q   <= wbData_d;
        end
    end

    // outputs
    assign pc          = pc_q;
    assign statusFlags = flags_q;
    assign branchTaken = branch_q;
    assign ioWrData    = ioWrData_q;
    assign wbValid     = wbValid_q;
    assign wbAddr      = wbAddr_q;
    assign wbData      = wbData_q;

endmodule
`default_nettype wire

// *** hw/reg_file_mem.sv ***
// general purpose register file, one write and one registered read port
`timescale 1ns/10ps
`default_nettype none
module reg_file_mem #(
    parameter int DEPTH  = 32,
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 5
) (
    // clock
    input  wire logic              clk_sys,
    // write port
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]  wrData,
    // read port, data one cycle after the address
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [WIDTH-1:0]  rdData
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdData_d;

    if (DEPTH > (1 << ADDR_W)) begin : g_chk
        $error("reg_file_mem: DEPTH exceeds address range");
    end

    // write-first read so a back-to-back update is seen
    always_comb begin
        rdData_d = rdData;
        if (rdEn) begin
            if (wrEn && (wrAddr == rdAddr)) begin
                rdData_d = wrData;
            end else begin
                rdData_d = mem[rdAddr];
            end
        end
    end

    // storage and read register
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= rdData_d;
    end

endmodule
`default_nettype wire

// *** tb/exec_props.sv ***
// assertion checker for the flag-branch, bit and shift executor
`timescale 1ns/10ps
`default_nettype none
module exec_props
    import exec_pkg::*;
#(
    parameter int PC_W   = 16,
    parameter int DISP_W = 7
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // issue port
    input wire logic              instrValid,
    input wire logic              instrReady,
    input wire op_t               instrOp,
    input wire logic [DISP_W-1:0] instrDisp,
    input wire logic [4:0]        instrReg,
    input wire logic [2:0]        instrBit,
    // state and results
    input wire logic              flagLoad,
    input wire logic [7:0]        statusFlags,
    input wire logic              wbValid,
    input wire logic [4:0]        wbAddr,
    input wire logic [7:0]        wbData,
    input wire logic [PC_W-1:0]   pc,
    input wire logic              branchTaken,
    input wire logic [7:0]        ioRdData,
    input wire logic              ioWrEn,
    input wire logic [7:0]        ioWrData
);
    logic acc;
    logic isBr;
    logic cond;

    // accept strobe and branch condition: flag equals the opcode polarity bit
    assign acc = instrValid && instrReady;
    assign isBr = instrOp inside {[OP_BRANCH_HALF_CARRY_SET:OP_BRANCH_IRQ_DISABLED]};
    always_comb begin
        case (instrOp)
            OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLR:
                cond = statusFlags[FLAG_HALF_CARRY] == instrOp[0];
            OP_BRANCH_TRANSFER_SET, OP_BRANCH_TRANSFER_CLR:
                cond = statusFlags[FLAG_TRANSFER] == instrOp[0];
            OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLR:
                cond = statusFlags[FLAG_OVERFLOW] == instrOp[0];
            default:
                cond = statusFlags[FLAG_IRQ_ENABLE] == instrOp[0];
        endcase
    end

    // branch target with sign-extended displacement
    function automatic logic [PC_W-1:0] tgt(logic [PC_W-1:0] p, logic [DISP_W-1:0] d);
        return p + {{(PC_W-DISP_W){d[DISP_W-1]}}, d} + 1'b1;
    endfunction

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    taken_timing_a: assert property (acc && isBr && cond |=>
        !instrReady ##1 instrReady ##1 branchTaken)
        else $error("taken branch timing wrong");
    taken_target_a: assert property (acc && isBr && cond |->
        ##3 pc == tgt($past(pc, 3), $past(instrDisp, 3)))
        else $error("taken branch target wrong");
    untaken_step_a: assert property (acc && isBr && !cond |=>
        instrReady ##1 (pc == $past(pc, 2) + 1'b1) && !branchTaken)
        else $error("untaken branch wrong");
    branch_flags_a: assert property (acc && isBr && !flagLoad |=>
        ##1 statusFlags == $past(statusFlags, 2))
        else $error("branch changed flags");
    taken_pulse_a: assert property (branchTaken |=> !branchTaken)
        else $error("branch pulse too long");
    // base is the pending write when a bit op is taken in the write cycle of the previous one
    set_bit_a: assert property (acc && instrOp == OP_SET_IO_BIT |-> ##2 ioWrEn &&
        ioWrData == (($past(ioWrEn, 2) ? $past(ioWrData, 2) : $past(ioRdData)) |
                     (8'h01 << $past(instrBit, 2))))
        else $error("set bit write wrong");
    clear_bit_a: assert property (acc && instrOp == OP_CLEAR_IO_BIT |-> ##2 ioWrEn &&
        ioWrData == (($past(ioWrEn, 2) ? $past(ioWrData, 2) : $past(ioRdData)) &
                     ~(8'h01 << $past(instrBit, 2))))
        else $error("clear bit write wrong");
    shift_left_a: assert property (acc && instrOp == OP_LOGICAL_SHIFT_LEFT |->
        ##2 wbValid && wbAddr == $past(instrReg, 2) && !wbData[0] &&
        statusFlags[FLAG_ZERO] == (wbData == 8'h00))
        else $error("left shift wrong");
    shift_right_a: assert property (acc && instrOp == OP_LOGICAL_SHIFT_RIGHT |->
        ##2 wbValid && wbAddr == $past(instrReg, 2) && !wbData[7] &&
        !statusFlags[FLAG_NEGATIVE])
        else $error("right shift wrong");
    shift_ovf_a: assert property (wbValid |->
        statusFlags[FLAG_OVERFLOW] == (statusFlags[FLAG_NEGATIVE] ^ statusFlags[FLAG_CARRY]))
        else $error("shift overflow flag wrong");

    // main scenarios
    cov_taken: cover property (acc && isBr && cond);
    cov_setbit: cover property (acc && instrOp == OP_SET_IO_BIT);
    cov_shr: cover property (acc && instrOp == OP_LOGICAL_SHIFT_RIGHT);
endmodule

bind flag_branch_bit_shift_exec exec_props #(.PC_W(PC_W), .DISP_W(DISP_W)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .instrValid(instrValid), .instrReady(instrReady),
    .instrOp(instrOp), .instrDisp(instrDisp), .instrReg(instrReg), .instrBit(instrBit),
    .flagLoad(flagLoad), .statusFlags(statusFlags), .wbValid(wbValid), .wbAddr(wbAddr),
    .wbData(wbData), .pc(pc), .branchTaken(branchTaken), .ioRdData(ioRdData),
    .ioWrEn(ioWrEn), .ioWrData(ioWrData)
);
`default_nettype wire

// *** tb/tb_flag_branch_bit_shift_exec.sv ***
// self-checking bench for the flag-branch, bit and shift executor
`timescale 1ns/10ps
`default_nettype none
module tb_flag_branch_bit_shift_exec
    import exec_pkg::*;
;
    logic        clk_sys, rst_n, instrValid, instrReady, flagLoad, regLoad;
    logic        wbValid, branchTaken, ioRdEn, ioWrEn;
    op_t         instrOp;
    logic [6:0]  instrDisp;
    logic [4:0]  instrReg, instrIoAddr, regLoadAddr, wbAddr, ioAddr;
    logic [2:0]  instrBit;
    logic [7:0]  flagLoadData, statusFlags, regLoadData, wbData, ioRdData, ioWrData;
    logic [15:0] pc, expPc;
    int          err_count, num_checks;

    // device under test
    flag_branch_bit_shift_exec u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .instrValid(instrValid), .instrReady(instrReady),
        .instrOp(instrOp), .instrDisp(instrDisp), .instrReg(instrReg),
        .instrIoAddr(instrIoAddr), .instrBit(instrBit), .flagLoad(flagLoad),
        .flagLoadData(flagLoadData), .statusFlags(statusFlags), .regLoad(regLoad),
        .regLoadAddr(regLoadAddr), .regLoadData(regLoadData), .wbValid(wbValid),
        .wbAddr(wbAddr), .wbData(wbData), .pc(pc), .branchTaken(branchTaken),
        .ioAddr(ioAddr), .ioRdEn(ioRdEn), .ioRdData(ioRdData), .ioWrEn(ioWrEn),
        .ioWrData(ioWrData)
    );

    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // offer one instruction, return at its accept edge
    task automatic issue(input op_t op, input logic [6:0] d, input logic [4:0] r,
                         input logic [4:0] a, input logic [2:0] b);
        int n;
        n = 0;
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrOp <= op;
        instrDisp <= d;
        instrReg <= r;
        instrIoAddr <= a;
        instrBit <= b;
        @(negedge clk_sys);
        while (instrReady !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk("accept", 1'b1, instrReady);
        chk("ioRdEn", 16'(op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT}), ioRdEn);
        @(posedge clk_sys);
        instrValid <= 1'b0;
    endtask

    task automatic setFlags(input logic [7:0] v);
        @(posedge clk_sys);
        flagLoad <= 1'b1;
        flagLoadData <= v;
        @(posedge clk_sys);
        flagLoad <= 1'b0;
        #1 chk("flagLoad", v, statusFlags);
    endtask

    task automatic loadReg(input logic [4:0] r, input logic [7:0] v);
        @(posedge clk_sys);
        regLoad <= 1'b1;
        regLoadAddr <= r;
        regLoadData <= v;
        @(posedge clk_sys);
        regLoad <= 1'b0;
    endtask

    // every branch opcode with its flag at both levels, others inverted
    task automatic testBranches();
        int         fb[4] = '{FLAG_HALF_CARRY, FLAG_TRANSFER, FLAG_OVERFLOW, FLAG_IRQ_ENABLE};
        logic [7:0] f;
        logic [6:0] d;
        logic       take;
        for (int i = 0; i < 8; i++) begin
            for (int v = 0; v < 2; v++) begin
                f = (v == 1) ? (8'h01 << fb[i/2]) : ~(8'h01 << fb[i/2]);
                d = (v == 1) ? 7'h7d : 7'h05;
                take = ((v == 1) == (i % 2 == 0));
                setFlags(f);
                issue(op_t'(i + 1), d, 5'h00, 5'h00, 3'h0);
                #1 chk("readyExec", !take, instrReady);
                @(posedge clk_sys);
                #1;
                if (take) begin
                    chk("pcHold", expPc, pc);
                    @(posedge clk_sys);
                    #1 expPc = expPc + {{9{d[6]}}, d} + 16'h0001;
                    chk("branchTaken", 1'b1, branchTaken);
                end else begin
                    expPc = expPc + 16'h0001;
                    chk("branchTaken", 1'b0, branchTaken);
                end
                chk("pc", expPc, pc);
                chk("flagsKept", f, statusFlags);
            end
        end
    endtask

    // set and clear of every bit position
    task automatic testBitOps();
        logic [7:0] old, exp;
        setFlags(8'ha5);
        for (int k = 0; k < 16; k++) begin
            old = (k < 8) ? 8'h00 : 8'hff;
            exp = (k < 8) ? (8'h01 << k[2:0]) : ~(8'h01 << k[2:0]);
            issue(op_t'((k < 8) ? OP_SET_IO_BIT : OP_CLEAR_IO_BIT), 7'h00, 5'h00, 5'(k),
                  k[2:0]);
            ioRdData <= old;
            #1 chk("ioWrEnEarly", 1'b0, ioWrEn);
            @(posedge clk_sys);
            ioRdData <= ~old;
            #1 chk("ioWrEn", 1'b1, ioWrEn);
            chk("ioWrData", exp, ioWrData);
            chk("ioAddr", 16'(k), ioAddr);
            chk("flagsKept", 8'ha5, statusFlags);
            @(posedge clk_sys);
            #1 expPc = expPc + 16'h0001;
            chk("pc", expPc, pc);
        end
    endtask

    // two set-bit ops on one i/o address, the second accepted while the first writes
    task automatic testBackToBack();
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrOp <= OP_SET_IO_BIT;
        instrIoAddr <= 5'h09;
        instrBit <= 3'h1;
        @(posedge clk_sys);
        ioRdData <= 8'h10;
        instrBit <= 3'h6;
        #1 chk("readyPairExec", 1'b0, instrReady);
        @(posedge clk_sys);
        #1 chk("ioWrDataFirst", 8'h12, ioWrData);
        chk("readyPairWrite", 1'b1, instrReady);
        @(posedge clk_sys);
        instrValid <= 1'b0;
        @(posedge clk_sys);
        #1 chk("ioWrEnFwd", 1'b1, ioWrEn);
        chk("ioWrDataFwd", 8'h52, ioWrData);
        @(posedge clk_sys);
        #1 expPc = expPc + 16'h0002;
        chk("pcPair", expPc, pc);
    endtask

    // shifts with carry out, zero and negative results
    task automatic testShifts();
        logic [7:0] v[4] = '{8'h81, 8'h40, 8'h01, 8'h80};
        logic [7:0] res, f;
        logic       c, left;
        setFlags(8'hf0);
        for (int i = 0; i < 4; i++) begin
            left = (i < 2);
            res = left ? {v[i][6:0], 1'b0} : {1'b0, v[i][7:1]};
            c = left ? v[i][7] : v[i][0];
            f = 8'hf0;
            f[FLAG_CARRY] = c;
            f[FLAG_ZERO] = (res == 8'h00);
            f[FLAG_NEGATIVE] = res[7];
            f[FLAG_OVERFLOW] = res[7] ^ c;
            loadReg(5'(i + 3), v[i]);
            issue(op_t'(left ? OP_LOGICAL_SHIFT_LEFT : OP_LOGICAL_SHIFT_RIGHT), 7'h00,
                  5'(i + 3), 5'h00, 3'h0);
            #1 chk("wbValidEarly", 1'b0, wbValid);
            @(posedge clk_sys);
            #1 expPc = expPc + 16'h0001;
            chk("wbValid", 1'b1, wbValid);
            chk("wbAddr", 16'(i + 3), wbAddr);
            chk("wbData", res, wbData);
            chk("flags", f, statusFlags);
            chk("pc", expPc, pc);
        end
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        instrValid = 1'b0;
        instrOp = OP_NONE;
        instrDisp = 7'h00;
        instrReg = 5'h00;
        instrIoAddr = 5'h00;
        instrBit = 3'h0;
        flagLoad = 1'b0;
        flagLoadData = 8'h00;
        regLoad = 1'b0;
        regLoadAddr = 5'h00;
        regLoadData = 8'h00;
        ioRdData = 8'h00;
        err_count = 0;
        num_checks = 0;
        expPc = 16'h0000;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("pcReset", 16'h0000, pc);
        chk("flagsReset", 8'h00, statusFlags);
        chk("readyReset", 1'b1, instrReady);
        testBranches();
        testBitOps();
        testBackToBack();
        testShifts();
        results();
    end

    // watchdog
    initial begin
        #(4000 * 8);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
